// >>> ctxs_decode.sv
`timescale 1ns/1ps
module ctxs_decode
   import ctxs_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic extCfg,
   input wire logic [15:0] instrWord,
   input wire logic instrLong,
   input wire logic [3:0] bankSel,
   input wire logic [DATA_W-1:0] fileRdData,
   output logic instrTake,
   output ctxs_file_t fileReq,
   output logic [DATA_W-1:0] accum,
   output ctxs_ptrs_t pointers,
   output logic flagN,
   output logic flagZ,
   output logic returnToTos,
   output logic callViaAcc,
   output logic foreignOp,
   output logic extActive
);
   ctxs_state_t s_q;
   ctxs_state_t s_d;
   logic rstMeta_q;
   logic rstSyncN_q;
   logic extMeta_q;
   logic extSync_q;
   logic exec;
   logic opTst, opXorl, opXorf, opPtr, opCallw, opPush, opMovs;
   logic [DATA_W-1:0] res;
   logic updNz;
   logic [1:0] ptrIdx;
   logic [ADDR_W-1:0] ptrStep;
   logic [ADDR_W-1:0] frameNow;
   logic [DATA_W-1:0] irLit;

   // reset release through two flops
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_q <= 1'b0;
         rstSyncN_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSyncN_q <= rstMeta_q;
      end
   end

   // config bit synchroniser, free running so it is settled when reset lifts
   always_ff @(posedge mclk) begin
      extMeta_q <= extCfg;
      extSync_q <= extMeta_q;
   end

   // decode of the held instruction word
   assign exec = (s_q.ph == PH_Q3) && !s_q.kill && !s_q.movePend;
   assign opTst = s_q.ir[15:9] == OPC_TST;
   assign opXorl = s_q.ir[15:8] == OPC_XORL;
   assign opXorf = s_q.ir[15:10] == OPC_XORF;
   assign opPtr = s_q.ir[15:9] == OPC_PTR;
   assign opCallw = s_q.ir == OPC_CALL_VIA_ACCUMULATOR;
   assign opPush = s_q.ir[15:8] == OPC_PUSH;
   assign opMovs = s_q.ir[15:8] == OPC_MOVS;
   assign ptrIdx = (s_q.ir[7:6] == SEL_FRAME) ? IDX_FRAME : s_q.ir[7:6];
   assign ptrStep = {6'h00, s_q.ir[5:0]};
   assign frameNow = s_q.indirect_pointer_register[IDX_FRAME];
   assign irLit = s_q.ir[7:0];

   // phase sequencer and execution
   always_comb begin
      s_d = s_q;
      res = '0;
      updNz = 1'b0;
      s_d.file.we = 1'b0;
      s_d.retPulse = 1'b0;
      s_d.callPulse = 1'b0;
      s_d.foreign = 1'b0;
      unique case (s_q.ph)
         PH_Q1: begin
            s_d.ph = PH_Q2;
            s_d.ir = instrWord;
            s_d.extEn = extSync_q;
            s_d.kill = s_q.skipNext | s_q.flushNext;
            // long skipped word costs one more
            s_d.skipNext = s_q.skipNext & (instrLong | (instrWord[15:8] == OPC_MOVS));
            s_d.flushNext = 1'b0;
            if (s_q.movePend) begin
               s_d.file.addr = s_q.moveToIdx ?
                  s_q.indirect_pointer_register[IDX_FRAME] + {5'h00, instrWord[6:0]} : instrWord[11:0];
            end else if (extSync_q && (instrWord[15:8] == OPC_PUSH)) begin
               s_d.file.addr = s_q.indirect_pointer_register[IDX_FRAME];
            end else if (extSync_q && (instrWord[15:8] == OPC_MOVS)) begin
               s_d.file.addr = s_q.indirect_pointer_register[IDX_FRAME] + {5'h00, instrWord[6:0]};
            end else begin
               s_d.file.addr = fileAddrOf(instrWord[7:0], instrWord[8], bankSel,
                  s_q.indirect_pointer_register[IDX_FRAME], extSync_q);
            end
         end
         PH_Q2: begin
            s_d.ph = PH_Q3;
         end
         PH_Q3: begin
            s_d.ph = PH_Q4;
            if (s_q.movePend && !s_q.kill) begin
               s_d.movePend = 1'b0;
               if (s_q.ir[15:12] == WORD2_TAG) begin
                  s_d.file.we = 1'b1;
                  s_d.file.wdata = s_q.moveData;
               end else begin
                  s_d.foreign = 1'b1;
               end
            end else if (exec) begin
               if (opTst) begin
                  s_d.skipNext = (fileRdData == 8'h00);
               end else if (opXorl) begin
                  res = s_q.accum ^ s_q.ir[7:0];
                  s_d.accum = res;
                  updNz = 1'b1;
               end else if (opXorf) begin
                  res = s_q.accum ^ fileRdData;
                  updNz = 1'b1;
                  if (s_q.ir[9]) begin
                     s_d.file.we = 1'b1;
                     s_d.file.wdata = res;
                  end else begin
                     s_d.accum = res;
                  end
               end else if (s_q.extEn && opPtr) begin
                  s_d.indirect_pointer_register[ptrIdx] = s_q.ir[8] ? s_q.indirect_pointer_register[ptrIdx] - ptrStep
                     : s_q.indirect_pointer_register[ptrIdx] + ptrStep;
                  if (s_q.ir[7:6] == SEL_FRAME) begin
                     s_d.retPulse = 1'b1;
                     s_d.flushNext = 1'b1;
                  end
               end else if (s_q.extEn && opCallw) begin
                  s_d.callPulse = 1'b1;
                  s_d.flushNext = 1'b1;
               end else if (s_q.extEn && opPush) begin
                  s_d.file.we = 1'b1;
                  s_d.file.wdata = s_q.ir[7:0];
                  s_d.indirect_pointer_register[IDX_FRAME] = s_q.indirect_pointer_register[IDX_FRAME] - 12'h001;
               end else if (s_q.extEn && opMovs) begin
                  // hold source byte for word two
                  s_d.moveData = fileRdData;
                  s_d.moveToIdx = s_q.ir[7];
                  s_d.movePend = 1'b1;
               end else begin
                  s_d.foreign = 1'b1;
               end
               if (updNz) begin
                  s_d.flagN = res[7];
                  s_d.flagZ = (res == 8'h00);
               end
            end
         end
         PH_Q4: begin
            s_d.ph = PH_Q1;
         end
         default: begin
            s_d.ph = PH_Q1;
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk or negedge rstSyncN_q) begin
      if (!rstSyncN_q)
         s_q <= STATE_RST;
      else
         s_q <= s_d;
   end

   // outputs straight from state
   assign instrTake = s_q.ph[0];
   assign fileReq = s_q.file;
   assign accum = s_q.accum;
   assign pointers = s_q.indirect_pointer_register;
   assign flagN = s_q.flagN;
   assign flagZ = s_q.flagZ;
   assign returnToTos = s_q.retPulse;
   assign callViaAcc = s_q.callPulse;
   assign foreignOp = s_q.foreign;
   assign extActive = s_q.extEn;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstSyncN_q);

   property p_skip_zero;
      exec && opTst && (fileRdData == 8'h00) |=> s_q.skipNext ##2 s_q.kill;
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("zero test did not skip");

   property p_skip_long;
      (s_q.ph == PH_Q1) && s_q.skipNext && instrLong |=> s_q.kill ##4 s_q.kill;
   endproperty
   a_skip_long: assert property (p_skip_long) else $error("long skip not two nops");

   property p_kill_quiet;
      s_q.kill && (s_q.ph == PH_Q4) |-> !fileReq.we && !returnToTos && !callViaAcc;
   endproperty
   a_kill_quiet: assert property (p_kill_quiet) else $error("killed cycle wrote");

   property p_xorl;
      exec && opXorl |=> accum == ($past(accum) ^ $past(irLit)) && flagZ == (accum == 8'h00);
   endproperty
   a_xorl: assert property (p_xorl) else $error("literal xor wrong");

   property p_xorf_file;
      exec && opXorf && s_q.ir[9] |=> fileReq.we && $stable(accum)
         && fileReq.wdata == ($past(accum) ^ $past(fileRdData));
   endproperty
   a_xorf_file: assert property (p_xorf_file) else $error("file xor wrong");

   property p_frame_return;
      exec && s_q.extEn && opPtr && (s_q.ir[7:6] == SEL_FRAME) |=> returnToTos ##2 s_q.kill;
   endproperty
   a_frame_return: assert property (p_frame_return) else $error("no return");

   property p_ptr_flags;
      exec && s_q.extEn && opPtr |=> $stable(flagN) && $stable(flagZ) && !fileReq.we;
   endproperty
   a_ptr_flags: assert property (p_ptr_flags) else $error("pointer op touched flags");

   property p_push;
      exec && s_q.extEn && opPush |=> fileReq.we && fileReq.wdata == $past(irLit)
         && frameNow == $past(frameNow) - 12'h001;
   endproperty
   a_push: assert property (p_push) else $error("push wrong");

   property p_ext_off;
      exec && !s_q.extEn && (opPush || opMovs || opCallw) |=> foreignOp && !fileReq.we;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("extension ran disabled");

   c_skip: cover property (exec && opTst && (fileRdData == 8'h00));
   c_skip_long: cover property ((s_q.ph == PH_Q1) && s_q.skipNext && instrLong);
   c_move: cover property (s_q.movePend ##4 fileReq.we);
   c_return: cover property (returnToTos);
endmodule

// >>> ctxs_file_model.sv
`timescale 1ns/1ps
module ctxs_file_model
   import ctxs_pkg::*;
(
   input wire logic mclk,
   input wire ctxs_file_t fileReq,
   output logic [DATA_W-1:0] fileRdData
);
   logic [DATA_W-1:0] mem [0:4095];
   // read path follows the address with no delay
   assign fileRdData = mem[fileReq.addr];
   // write strobe stores data at the addressed register
   always @(posedge mclk) begin
      if (fileReq.we === 1'b1) begin
         mem[fileReq.addr] <= fileReq.wdata;
      end
   end
endmodule

// >>> ctxs_pkg.sv
package ctxs_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   // opcode match fields
   localparam logic [6:0] OPC_TST = 7'h33;
   localparam logic [7:0] OPC_XORL = 8'h0A;
   localparam logic [5:0] OPC_XORF = 6'h06;
   localparam logic [6:0] OPC_PTR = 7'h74;
   localparam logic [7:0] OPC_PUSH = 8'hEA;
   localparam logic [7:0] OPC_MOVS = 8'hEB;
   localparam logic [15:0] OPC_CALL_VIA_ACCUMULATOR = 16'h0014;
   localparam logic [3:0] WORD2_TAG = 4'hF;
   // addressing
   localparam logic [7:0] IDX_LIMIT = 8'h5F;
   localparam logic [1:0] SEL_FRAME = 2'h3;
   localparam logic [1:0] IDX_FRAME = 2'h2;
   localparam logic [3:0] ACC_LOW_BANK = 4'h0;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
   // reset values
   localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic EXT_RST = 1'b1;

   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } ctxs_phase_t;

   typedef logic [2:0][ADDR_W-1:0] ctxs_ptrs_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic we;
      logic [DATA_W-1:0] wdata;
   } ctxs_file_t;

   typedef struct packed {
      ctxs_phase_t ph;
      logic [15:0] ir;
      logic kill;
      logic skipNext;
      logic flushNext;
      logic movePend;
      logic moveToIdx;
      logic [DATA_W-1:0] moveData;
      logic [DATA_W-1:0] accum;
      ctxs_ptrs_t indirect_pointer_register;
      logic flagN;
      logic flagZ;
      ctxs_file_t file;
      logic retPulse;
      logic callPulse;
      logic foreign;
      logic extEn;
   } ctxs_state_t;

   localparam ctxs_state_t STATE_RST = '{ph: PH_Q1, accum: ACC_RST,
      indirect_pointer_register: {PTR_RST, PTR_RST, PTR_RST}, extEn: EXT_RST, default: '0};

   // file operand address: banked, shared bank or frame-indexed
   function automatic logic [ADDR_W-1:0] fileAddrOf(input logic [7:0] f, input logic a,
         input logic [3:0] bank_select_register, input logic [ADDR_W-1:0] frame, input logic ext);
      if (a)
         return {bank_select_register, f};
      else if (ext && (f <= IDX_LIMIT))
         return frame + {4'h0, f};
      else
         return {(f > IDX_LIMIT) ? ACC_HIGH_BANK : ACC_LOW_BANK, f};
   endfunction
endpackage

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top
   import ctxs_pkg::*;
;
   typedef struct packed {
      logic [15:0] w;
      logic [7:0] acc;
      logic [1:0] nz;
      logic [15:0] cnt;
      ctxs_ptrs_t p;
   } ctxs_row_t;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic extCfg = 1'b1;
   logic instrLong = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic [3:0] bankSel = 4'h1;
   logic [DATA_W-1:0] fileRdData;
   ctxs_file_t fileReq;
   ctxs_ptrs_t pointers;
   logic [DATA_W-1:0] accum;
   logic instrTake, flagN, flagZ, returnToTos, callViaAcc, foreignOp, extActive;
   int fail_count = 0;
   int check_count = 0;
   int nWe, nRet, nCall, nFgn;
   ctxs_row_t rows [12] = '{
      '{16'h0A55, 8'h55, 2'h0, 16'h0000, 36'h0},
      '{16'h0AFF, 8'hAA, 2'h2, 16'h0000, 36'h0},
      '{16'h0AAA, 8'h00, 2'h1, 16'h0000, 36'h0},
      '{16'h1920, 8'h3C, 2'h0, 16'h0000, 36'h0},
      '{16'h1B21, 8'h3C, 2'h2, 16'h1000, 36'h0},
      '{16'hE83F, 8'h3C, 2'h2, 16'h0000, 36'h00000003F},
      '{16'hE94F, 8'h3C, 2'h2, 16'h0000, 36'h000FF103F},
      '{16'hE8A3, 8'h3C, 2'h2, 16'h0000, 36'h023FF103F},
      '{16'hEA77, 8'h3C, 2'h2, 16'h1000, 36'h022FF103F},
      '{16'h0000, 8'h3C, 2'h2, 16'h0001, 36'h022FF103F},
      '{16'h1810, 8'h33, 2'h0, 16'h0000, 36'h022FF103F},
      '{16'h1880, 8'h00, 2'h1, 16'h0000, 36'h022FF103F}};

   ctxs_decode u_ctxs_decode (.mclk(mclk), .arst_n(arst_n), .extCfg(extCfg),
      .instrWord(instrWord), .instrLong(instrLong), .bankSel(bankSel),
      .fileRdData(fileRdData), .instrTake(instrTake), .fileReq(fileReq), .accum(accum),
      .pointers(pointers), .flagN(flagN), .flagZ(flagZ), .returnToTos(returnToTos),
      .callViaAcc(callViaAcc), .foreignOp(foreignOp), .extActive(extActive));
   ctxs_file_model u_ctxs_file_model (.mclk(mclk), .fileReq(fileReq),
      .fileRdData(fileRdData));

   // clock and pulse counters
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      nWe += int'(fileReq.we === 1'b1);
      nRet += int'(returnToTos === 1'b1);
      nCall += int'(callViaAcc === 1'b1);
      nFgn += int'(foreignOp === 1'b1);
   end

   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // present one word in a take slot, return at the next take slot
   task automatic issue(input logic [15:0] w, input logic lng);
      int n;
      n = 0;
      while (instrTake !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      instrWord = w;
      instrLong = lng;
      {nWe, nRet, nCall, nFgn} = '0;
      @(negedge mclk);
      n = 0;
      while (instrTake !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic finish_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      #5000;
      fail_count++;
      finish_test();
   end

   // main sequence
   initial begin
      u_ctxs_file_model.mem[12'h120] = 8'h3C;
      u_ctxs_file_model.mem[12'h121] = 8'hC3;
      u_ctxs_file_model.mem[12'h032] = 8'h0F;
      u_ctxs_file_model.mem[12'hF80] = 8'h33;
      u_ctxs_file_model.mem[12'h124] = 8'h00;
      u_ctxs_file_model.mem[12'h125] = 8'h05;
      u_ctxs_file_model.mem[12'h028] = 8'h5A;
      u_ctxs_file_model.mem[12'h010] = 8'h01;
      u_ctxs_file_model.mem[12'h210] = 8'h0F;
      repeat (4) @(negedge mclk);
      arst_n = 1'b1;
      repeat (2) @(negedge mclk);
      check("rst", {extActive, accum, pointers}, {1'b1, 8'h00, 36'h0});
      // table of single-cycle operations
      foreach (rows[i]) begin
         issue(rows[i].w, 1'b0);
         check("acc", accum, rows[i].acc);
         check("nz", {flagN, flagZ}, rows[i].nz);
         check("cnt", {nWe[3:0], nRet[3:0], nCall[3:0], nFgn[3:0]}, rows[i].cnt);
         check("ptr", pointers, rows[i].p);
      end
      check("xorf", u_ctxs_file_model.mem[12'h121], 8'hFF);
      check("push", u_ctxs_file_model.mem[12'h023], 8'h77);
      // zero test: long skip, short skip, no skip
      issue(16'h6724, 1'b0);
      check("tstz", {flagN, flagZ, nWe[3:0]}, {2'h1, 4'h0});
      issue(16'h0A01, 1'b1);
      check("skw", nWe + nFgn, 0);
      issue(16'h0A02, 1'b0);
      issue(16'h0A04, 1'b0);
      check("skl", accum, 8'h04);
      issue(16'h6724, 1'b0);
      issue(16'h0A10, 1'b0);
      issue(16'h0A20, 1'b0);
      check("sks", accum, 8'h24);
      issue(16'h6725, 1'b0);
      issue(16'h0A08, 1'b0);
      check("nsk", accum, 8'h2C);
      // frame add with return, then call, each flushes one word
      issue(16'hE8C1, 1'b0);
      check("ret", {nRet[3:0], pointers[2]}, {4'h1, 12'h023});
      issue(16'h0A01, 1'b0);
      issue(16'h0014, 1'b0);
      check("call", {nCall[3:0], nWe[3:0]}, 8'h10);
      issue(16'h0A01, 1'b0);
      check("fl", accum, 8'h2C);
      // indexed move frame+5 to file 300
      issue(16'hEB05, 1'b1);
      issue(16'hF300, 1'b0);
      check("mov", u_ctxs_file_model.mem[12'h300], 8'h5A);
      // frame subtract with return, then an index-to-index move
      issue(16'hE9C2, 1'b0);
      check("subr", {nRet[3:0], pointers[2]}, {4'h1, 12'h021});
      issue(16'h0A01, 1'b0);
      check("subf", {nWe[3:0], accum}, {4'h0, 8'h2C});
      issue(16'hEB87, 1'b1);
      issue(16'hF00B, 1'b0);
      check("movs", u_ctxs_file_model.mem[12'h02C], 8'h5A);
      // extension switched off
      extCfg = 1'b0;
      repeat (12) @(negedge mclk);
      check("ext", extActive, 1'b0);
      issue(16'hE83F, 1'b0);
      check("off", {nFgn[3:0], pointers}, {4'h1, 36'h021FF103F});
      issue(16'h1810, 1'b0);
      check("dir", accum, 8'h2D);
      issue(16'hEA55, 1'b0);
      check("offp", {nFgn[3:0], nWe[3:0], pointers[2]}, {4'h1, 4'h0, 12'h021});
      // bank register picks the page for banked operands
      bankSel = 4'h2;
      issue(16'h1910, 1'b0);
      check("bank", accum, 8'h22);
      // reset in mid-run with the extension configured off
      arst_n = 1'b0;
      repeat (4) @(negedge mclk);
      check("rst2", {instrTake, extActive, accum, pointers}, {2'h3, 8'h00, 36'h0});
      arst_n = 1'b1;
      repeat (2) @(negedge mclk);
      issue(16'hEA55, 1'b0);
      check("rstx", {extActive, nFgn[3:0], nWe[3:0]}, {1'b0, 4'h1, 4'h0});
      finish_test();
   end
endmodule
